/* File: supply_fault_defs.svh */
// Behaviour
// [RULE1] Serial mode: pump monitor disable bit high turns off the pump comparator.
// [RULE2] Parallel mode: pump enable pin low turns off the pump comparator.
// [RULE3] Combined fault is the OR of core and pump comparator results.
// [RULE4] Fault pin pulled low while any supply fault exists, released otherwise.
// [RULE5] Fault pin stays released until both supplies first pass their enable thresholds.
// [RULE6] After arming, a supply drop pulls the pin low and sets status bit 6.
// [RULE7] Fault pin releases by itself once the fault condition goes away.
// [RULE8] Status flag stays latched until the host clears it by serial write.
// [RULE9] Shutdown enabled: a fault forces all switch outputs low and stops the pump.
// [RULE10] Host restarts after shutdown by driving pump enable low then high.
// [RULE11] Shutdown disabled: no protective action on a fault.
// [RULE12] Shutdown disabled: fault still reported, pump and switches unchanged.
// [RULE13] The healthy supply keeps being monitored while the other is faulted.
// [RULE14] Combined fault holds until both supplies are back above trip levels.
// [RULE15] The I/O supply is monitored only when tied to the core supply.
// [RULE16] Mode pin 0 selects serial register control, 1 selects parallel pins.
// [RULE17] Serial mode ignores pump enable and shutdown pins, uses register bits.
// [RULE18] Host clears a latched fault by writing 0 to the status flag.
// [RULE19] Comparator outputs are synchronised before being combined, latched or used.
// [RULE20] Status flag, pump enable, shutdown and monitor disable bits reset low.
`ifndef SUPPLY_FAULT_DEFS_SVH
`define SUPPLY_FAULT_DEFS_SVH

// ----------------------------------------
// Field positions in the control byte
// ----------------------------------------
`define CTRL_WR_EN_BIT 7
`define CTRL_FAULT_STATUS_FLAG_BIT 6
`define CTRL_SLEEP_BIT 5
`define CTRL_SHUTDOWN_MASK_BIT 4
`define CTRL_PUMP_MON_DIS_BIT 3
`define CTRL_PUMP_EN_BIT 1

// ----------------------------------------
// Reset values, widths and mode encoding
// ----------------------------------------
`define CTRL_RESET 8'h00
`define HV_OUT_WIDTH 4
`define MODE_SERIAL 1'b0

`endif

/* File: supply_fault_pkg.sv */
package supply_fault_pkg;

    // ----------------------------------------
    // Settings as seen by the fault logic
    // ----------------------------------------
    typedef struct packed {
        logic pump_enable;
        logic shutdown_mask;
        logic pump_monitor_disable;
    } fault_cfg_t;

    // Raw comparator levels; the under bits are high when under voltage, the above bits when above
    typedef struct packed {
        logic core_under;
        logic pump_under;
        logic io_under;
        logic core_above_rise;
        logic pump_above_enable;
    } supply_cmp_t;

    // Supervisor life cycle
    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_ARMED = 2'b01,
        ST_SHUTDOWN = 2'b11
    } sup_state_t;

endpackage : supply_fault_pkg

/* File: supply_fault_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "supply_fault_defs.svh"

module supply_fault_supervisor (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // Mode pin, parallel pins and I/O strap
    input wire logic MODE_PIN,
    input wire logic PUMP_ENABLE_PIN,
    input wire logic SHUTDOWN_MASK_SELECT,
    input wire logic IO_TIED_TO_CORE,
    // Analog comparator levels, asynchronous
    input wire supply_fault_pkg::supply_cmp_t CMP,
    // Serial control register write port and readback
    input wire logic CTRL_WR,
    input wire logic [7:0] CTRL_WDATA,
    output logic [7:0] CTRL_RDATA,
    // Requested switch states
    input wire logic [3:0] HV_REQUEST,
    // Outputs
    output logic [3:0] HV_OUT,
    output logic PUMP_RUN,
    output logic COMBINED_SUPPLY_FAULT,
    output logic FAULT_STATUS_FLAG,
    output logic SUPPLY_FAULT_PIN_N_OUT,
    output logic SUPPLY_FAULT_PIN_N_OE_N
);
    import supply_fault_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Comparators, the two parallel pins and the I/O strap, all asynchronous
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] clean;

    assign raw_in = {CMP, PUMP_ENABLE_PIN, SHUTDOWN_MASK_SELECT, IO_TIED_TO_CORE};

    // Three stages; a change counts only once stage two and three agree
    // Costs four edges of latency, traded for immunity to comparator chatter
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    s1[gi] <= 1'b0;
                    s2[gi] <= 1'b0;
                    s3[gi] <= 1'b0;
                    clean[gi] <= 1'b0;
                end else begin
                    s1[gi] <= raw_in[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (s2[gi] == s3[gi]) begin
                        clean[gi] <= s3[gi];  // see [RULE19]
                    end
                end
            end
        end
    endgenerate

    // Settled views; nothing downstream reads these comparators or pins raw
    supply_cmp_t cmp_sync;
    logic pin_pump_en;
    logic pin_shutdown_mask;
    logic io_tied;
    assign cmp_sync = clean[7:3];
    assign pin_pump_en = clean[2];
    assign pin_shutdown_mask = clean[1];
    assign io_tied = clean[0];

    // Mode pin is a strap: treat it as quasi-static, but still resync
    // Resets to serial so register bits rule until the strap is seen
    logic mode_s1;
    logic mode_s2;
    logic mode_s3;
    logic serial_mode;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            mode_s1 <= 1'b0;
            mode_s2 <= 1'b0;
            mode_s3 <= 1'b0;
            serial_mode <= 1'b1;
        end else begin
            mode_s1 <= MODE_PIN;
            mode_s2 <= mode_s1;
            mode_s3 <= mode_s2;
            if (mode_s2 == mode_s3) begin
                serial_mode <= (mode_s3 == `MODE_SERIAL);  // see [RULE16]
            end
        end
    end

    // ----------------------------------------
    // Serial control register
    // ----------------------------------------
    logic pump_enable_bit;
    logic shutdown_mask_bit;
    logic pump_monitor_disable;
    logic sleep_bit;
    logic ctrl_write;
    logic status_clear;

    // A word without its write-enable bit is a read only and changes nothing
    assign ctrl_write = CTRL_WR && CTRL_WDATA[`CTRL_WR_EN_BIT];
    // Only a zero in the status position clears; a one there is harmless
    assign status_clear = ctrl_write && !CTRL_WDATA[`CTRL_FAULT_STATUS_FLAG_BIT];

    // Write only lands when the write-enable bit of the word is set
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            pump_enable_bit <= 1'b0;  // see [RULE20]
            shutdown_mask_bit <= 1'b0;
            pump_monitor_disable <= 1'b0;
            sleep_bit <= 1'b0;
        end else if (ctrl_write) begin
            pump_enable_bit <= CTRL_WDATA[`CTRL_PUMP_EN_BIT];
            shutdown_mask_bit <= CTRL_WDATA[`CTRL_SHUTDOWN_MASK_BIT];
            pump_monitor_disable <= CTRL_WDATA[`CTRL_PUMP_MON_DIS_BIT];
            sleep_bit <= CTRL_WDATA[`CTRL_SLEEP_BIT];
        end
    end

    // ----------------------------------------
    // Effective configuration by mode
    // ----------------------------------------
    // Pins and register bits are never mixed: the mode picks one whole set
    fault_cfg_t cfg;
    always_comb begin
        if (serial_mode) begin
            cfg.pump_enable = pump_enable_bit;  // see [RULE17]
            cfg.shutdown_mask = shutdown_mask_bit;
            cfg.pump_monitor_disable = pump_monitor_disable;  // see [RULE1]
        end else begin
            cfg.pump_enable = pin_pump_en;
            cfg.shutdown_mask = pin_shutdown_mask;
            cfg.pump_monitor_disable = !pin_pump_en;  // see [RULE2]
        end
    end

    // ----------------------------------------
    // Fault detection
    // ----------------------------------------
    logic core_fault;
    logic pump_fault;
    logic io_fault;
    logic any_fault;
    sup_state_t state;
    sup_state_t next_state;

    // Each comparator stands on its own, so one fault never masks the other
    assign core_fault = cmp_sync.core_under;  // see [RULE13]
    assign pump_fault = cmp_sync.pump_under && !cfg.pump_monitor_disable;
    assign io_fault = cmp_sync.io_under && io_tied;  // see [RULE15]
    assign any_fault = core_fault || pump_fault || io_fault;  // see [RULE3] [RULE14]

    // Fault only counts once both supplies have passed start thresholds
    // Before that the comparators may chatter while the rails ramp
    logic armed;
    assign armed = (state != ST_STARTUP);

    // ----------------------------------------
    // Supervisor state machine
    // ----------------------------------------
    logic pump_en_prev;
    logic pump_en_rise_after_low;
    logic saw_pump_low;

    // Last cycle's pump enable, for the restart edge
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            pump_en_prev <= 1'b0;
        end else begin
            pump_en_prev <= cfg.pump_enable;
        end
    end

    // Restart needs a low then a high on pump enable after the trip
    // The low must be seen while shut down; an earlier low does not count
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            saw_pump_low <= 1'b0;
        end else if (state != ST_SHUTDOWN) begin
            saw_pump_low <= 1'b0;
        end else if (!cfg.pump_enable) begin
            saw_pump_low <= 1'b1;  // see [RULE10]
        end
    end
    assign pump_en_rise_after_low = saw_pump_low && cfg.pump_enable && !pump_en_prev;

    // Shutdown holds after the fault clears; only the restart edge leaves it
    always_comb begin
        next_state = state;
        unique case (state)
            ST_STARTUP: begin
                if (cmp_sync.core_above_rise && cmp_sync.pump_above_enable) begin
                    next_state = ST_ARMED;  // see [RULE5]
                end
            end
            ST_ARMED: begin
                if (any_fault && !cfg.shutdown_mask) begin
                    next_state = ST_SHUTDOWN;  // see [RULE9]
                end
            end
            ST_SHUTDOWN: begin
                if (pump_en_rise_after_low) begin
                    next_state = ST_ARMED;
                end
            end
            default: next_state = ST_STARTUP;
        endcase
    end

    // Arming is one-way: a later dip of the start levels never returns to startup
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state <= ST_STARTUP;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Fault pin and combined indication
    // ----------------------------------------
    // Follows the live fault, so it clears without host help
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            COMBINED_SUPPLY_FAULT <= 1'b0;
        end else begin
            COMBINED_SUPPLY_FAULT <= armed && any_fault;  // see [RULE4] [RULE7]
        end
    end

    // Open drain: drive low with enable low, otherwise released
    // Data stays low; only the enable moves, so the pin never drives high
    assign SUPPLY_FAULT_PIN_N_OUT = 1'b0;
    assign SUPPLY_FAULT_PIN_N_OE_N = !COMBINED_SUPPLY_FAULT;  // see [RULE4]

    // ----------------------------------------
    // Sticky status flag
    // ----------------------------------------
    // A new fault in the clearing cycle wins over the clear
    // so a host clearing during a live fault never loses it
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            FAULT_STATUS_FLAG <= 1'b0;  // see [RULE20]
        end else if (armed && any_fault) begin
            FAULT_STATUS_FLAG <= 1'b1;  // see [RULE6]
        end else if (status_clear) begin
            FAULT_STATUS_FLAG <= 1'b0;  // see [RULE8] [RULE18]
        end
    end

    // ----------------------------------------
    // Protective outputs
    // ----------------------------------------
    // Shutdown state overrides; with shutdown masked nothing changes
    // Keyed on the next state so switches open on the same edge as the flag
    // Sleep stops the pump only in serial mode, where the register bit rules
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            HV_OUT <= '0;
            PUMP_RUN <= 1'b0;
        end else if (next_state == ST_SHUTDOWN) begin
            HV_OUT <= '0;  // see [RULE9]
            PUMP_RUN <= 1'b0;
        end else begin
            HV_OUT <= HV_REQUEST;  // see [RULE11] [RULE12]
            PUMP_RUN <= cfg.pump_enable && !(serial_mode && sleep_bit);
        end
    end

    // ----------------------------------------
    // Control readback
    // ----------------------------------------
    // Built from field positions; write enable and don't-care bits read 0
    logic [7:0] next_ctrl_rdata;
    always_comb begin
        next_ctrl_rdata = `CTRL_RESET;
        next_ctrl_rdata[`CTRL_FAULT_STATUS_FLAG_BIT] = FAULT_STATUS_FLAG;
        next_ctrl_rdata[`CTRL_SLEEP_BIT] = sleep_bit;
        next_ctrl_rdata[`CTRL_SHUTDOWN_MASK_BIT] = shutdown_mask_bit;
        next_ctrl_rdata[`CTRL_PUMP_MON_DIS_BIT] = pump_monitor_disable;
        next_ctrl_rdata[`CTRL_PUMP_EN_BIT] = pump_enable_bit;
    end

    // Registered so the readback is a clean flop output, one edge behind
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            CTRL_RDATA <= `CTRL_RESET;
        end else begin
            CTRL_RDATA <= next_ctrl_rdata;
        end
    end

endmodule : supply_fault_supervisor
`default_nettype wire

/* File: supply_fault_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_fault_chk (
    // Clock, reset and pins
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic MODE_PIN,
    input wire supply_fault_pkg::supply_cmp_t CMP,
    // Control word
    input wire logic CTRL_WR,
    input wire logic [7:0] CTRL_WDATA,
    input wire logic [7:0] CTRL_RDATA,
    // Outputs
    input wire logic [3:0] HV_OUT,
    input wire logic PUMP_RUN,
    input wire logic COMBINED_SUPPLY_FAULT,
    input wire logic FAULT_STATUS_FLAG,
    input wire logic SUPPLY_FAULT_PIN_N_OUT,
    input wire logic SUPPLY_FAULT_PIN_N_OE_N
);
    import supply_fault_pkg::*;
    logic any_under;
    logic core_u;
    logic clear_req;
    // Causes seen at the inputs
    assign any_under = CMP.core_under | CMP.pump_under | CMP.io_under;
    assign core_u = CMP.core_under;
    assign clear_req = CTRL_WR & CTRL_WDATA[7] & ~CTRL_WDATA[6];
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    pin_follows_a: assert property (SUPPLY_FAULT_PIN_N_OE_N == !COMBINED_SUPPLY_FAULT)
        else $error("fault pin enable disagrees with combined fault");
    pin_low_a: assert property (SUPPLY_FAULT_PIN_N_OUT == 1'b0)
        else $error("fault pin data is not low");
    flag_set_a: assert property (COMBINED_SUPPLY_FAULT |-> FAULT_STATUS_FLAG)
        else $error("live fault without status flag");
    flag_hold_a: assert property ($fell(FAULT_STATUS_FLAG) |-> $past(clear_req) || $past(clear_req, 2))
        else $error("status flag dropped without a clearing write");
    fault_cause_a: assert property ($rose(COMBINED_SUPPLY_FAULT) |-> $past(any_under, 3))
        else $error("combined fault rose without a settled cause");
    release_a: assert property ($fell(COMBINED_SUPPLY_FAULT) |-> !$past(core_u, 3))
        else $error("combined fault released while core still low");
    shutdown_a: assert property ($rose(COMBINED_SUPPLY_FAULT) && !MODE_PIN && !CTRL_RDATA[4]
        |-> HV_OUT == 4'h0 && !PUMP_RUN)
        else $error("fault did not shut outputs and pump");
    report_only_a: assert property ($rose(COMBINED_SUPPLY_FAULT) && !MODE_PIN && CTRL_RDATA[4]
        |-> $stable(PUMP_RUN))
        else $error("report only fault changed the pump");
    // Main scenarios reached
    cover property ($rose(COMBINED_SUPPLY_FAULT));
    cover property ($fell(FAULT_STATUS_FLAG));
    cover property ($rose(PUMP_RUN));
endmodule : supply_fault_chk
bind supply_fault_supervisor supply_fault_chk chk (.CLOCK, .RST_B, .MODE_PIN, .CMP, .CTRL_WR,
    .CTRL_WDATA, .CTRL_RDATA, .HV_OUT, .PUMP_RUN, .COMBINED_SUPPLY_FAULT, .FAULT_STATUS_FLAG,
    .SUPPLY_FAULT_PIN_N_OUT, .SUPPLY_FAULT_PIN_N_OE_N);
`default_nettype wire

/* File: supply_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_host_model (
    // Clock
    input wire logic CLOCK,
    // Control lines toward the supervisor
    output logic CTRL_WR,
    output logic [7:0] CTRL_WDATA,
    output logic PUMP_ENABLE_PIN
);
    // Pins idle low, as with their pull-downs
    initial begin
        CTRL_WR = 1'b0;
        CTRL_WDATA = 8'h00;
        PUMP_ENABLE_PIN = 1'b0;
    end
    // One-cycle write; data is scrambled afterwards so nothing leans on a stale word
    task write_ctrl(input logic [7:0] d);
        @(negedge CLOCK);
        CTRL_WR = 1'b1;
        CTRL_WDATA = d;
        @(negedge CLOCK);
        CTRL_WR = 1'b0;
        CTRL_WDATA = ~d;
    endtask : write_ctrl
    // Parallel pump enable level
    task set_pin(input logic v);
        @(negedge CLOCK);
        PUMP_ENABLE_PIN = v;
    endtask : set_pin
endmodule : supply_host_model
`default_nettype wire

/* File: test_supply_fault_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module test_supply_fault_supervisor;
    import supply_fault_pkg::*;
    logic CLOCK, RST_B, MODE_PIN, PUMP_ENABLE_PIN, SHUTDOWN_MASK_SELECT, IO_TIED_TO_CORE;
    logic CTRL_WR, PUMP_RUN, COMBINED_SUPPLY_FAULT, FAULT_STATUS_FLAG;
    logic SUPPLY_FAULT_PIN_N_OUT, SUPPLY_FAULT_PIN_N_OE_N;
    logic [7:0] CTRL_WDATA, CTRL_RDATA, st;
    logic [3:0] HV_REQUEST, HV_OUT;
    supply_cmp_t CMP;
    int n_mismatch = 0;
    int tests_run = 0;
    supply_fault_supervisor uut (.CLOCK, .RST_B, .MODE_PIN, .PUMP_ENABLE_PIN,
        .SHUTDOWN_MASK_SELECT, .IO_TIED_TO_CORE, .CMP, .CTRL_WR, .CTRL_WDATA, .CTRL_RDATA,
        .HV_REQUEST, .HV_OUT, .PUMP_RUN, .COMBINED_SUPPLY_FAULT, .FAULT_STATUS_FLAG,
        .SUPPLY_FAULT_PIN_N_OUT, .SUPPLY_FAULT_PIN_N_OE_N);
    supply_host_model host (.CLOCK, .CTRL_WR, .CTRL_WDATA, .PUMP_ENABLE_PIN);
    // Packed view: combined, pin enable, flag, pump, switches
    assign st = {COMBINED_SUPPLY_FAULT, SUPPLY_FAULT_PIN_N_OE_N, FAULT_STATUS_FLAG, PUMP_RUN, HV_OUT};
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end
    task report_and_stop;
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Synchroniser, agreement stage and output flop need five edges; eight leaves margin
    task settle;
        repeat (8) @(negedge CLOCK);
    endtask : settle
    task t_startup;
        chk(CTRL_RDATA, 8'h00);
        chk(st, 8'h40);
        CMP.core_under = 1'b1;
        settle;
        chk(st, 8'h40);
        CMP.core_under = 1'b0;
        CMP.core_above_rise = 1'b1;
        CMP.pump_above_enable = 1'b1;
        HV_REQUEST = 4'ha;
        settle;
        chk(st, 8'h4a);
    endtask : t_startup
    task t_shutdown;
        host.write_ctrl(8'h82);
        settle;
        chk(st, 8'h5a);
        CMP.core_under = 1'b1;
        settle;
        chk(st, 8'ha0);
        CMP.core_under = 1'b0;
        settle;
        chk(st, 8'h60);
        host.write_ctrl(8'h80);
        host.write_ctrl(8'h82);
        settle;
        chk(st, 8'h5a);
    endtask : t_shutdown
    task t_report;
        host.write_ctrl(8'h92);
        CMP.pump_under = 1'b1;
        settle;
        chk(st, 8'hba);
        chk(CTRL_RDATA, 8'h52);
        CMP.core_under = 1'b1;
        settle;
        CMP.pump_under = 1'b0;
        settle;
        chk(st, 8'hba);
        CMP.core_under = 1'b0;
        settle;
        chk(st, 8'h7a);
        host.write_ctrl(8'h92);
        settle;
        chk(st, 8'h5a);
    endtask : t_report
    task t_monitors;
        host.write_ctrl(8'h9a);
        CMP.pump_under = 1'b1;
        CMP.io_under = 1'b1;
        settle;
        chk(st, 8'h5a);
        IO_TIED_TO_CORE = 1'b1;
        settle;
        chk(st, 8'hba);
        CMP.io_under = 1'b0;
        settle;
        host.write_ctrl(8'h9a);
        MODE_PIN = 1'b1;
        SHUTDOWN_MASK_SELECT = 1'b1;
        settle;
        chk(st, 8'h4a);
        host.set_pin(1'b1);
        settle;
        chk(st, 8'hba);
        // Parallel shutdown by pin, then restart by toggling the enable pin
        SHUTDOWN_MASK_SELECT = 1'b0;
        settle;
        chk(st, 8'ha0);
        CMP.pump_under = 1'b0;
        host.set_pin(1'b0);
        settle;
        chk(st, 8'h60);
        host.set_pin(1'b1);
        settle;
        chk(st, 8'h7a);
    endtask : t_monitors
    // Mid-run reset with start levels gone: arming, bits and flag start over
    task t_reset;
        RST_B = 1'b0;
        MODE_PIN = 1'b0;
        SHUTDOWN_MASK_SELECT = 1'b0;
        IO_TIED_TO_CORE = 1'b0;
        CMP = '0;
        HV_REQUEST = 4'h5;
        host.set_pin(1'b0);
        repeat (3) @(negedge CLOCK);
        RST_B = 1'b1;
        chk(st, 8'h40);
        chk(CTRL_RDATA, 8'h00);
        CMP.core_under = 1'b1;
        settle;
        chk(st, 8'h45);
        CMP.core_under = 1'b0;
        CMP.core_above_rise = 1'b1;
        CMP.pump_above_enable = 1'b1;
        host.write_ctrl(8'h92);
        settle;
        chk(st, 8'h55);
        CMP.pump_under = 1'b1;
        settle;
        CMP.pump_under = 1'b0;
        settle;
        chk(st, 8'h75);
        // Status one does not clear; sleep stops the pump; don't-care bits read 0
        host.write_ctrl(8'hf7);
        settle;
        chk(st, 8'h65);
        chk(CTRL_RDATA, 8'h72);
    endtask : t_reset
    initial begin
        RST_B = 1'b0;
        MODE_PIN = 1'b0;
        SHUTDOWN_MASK_SELECT = 1'b0;
        IO_TIED_TO_CORE = 1'b0;
        CMP = '0;
        HV_REQUEST = 4'h0;
        repeat (10) @(negedge CLOCK);
        RST_B = 1'b1;
        t_startup;
        t_shutdown;
        t_report;
        t_monitors;
        t_reset;
        report_and_stop;
    end
    // Whole run is a few hundred cycles; this cuts a hang short
    initial begin
        #400000;
        n_mismatch++;
        report_and_stop;
    end
endmodule : test_supply_fault_supervisor
`default_nettype wire
